/* File: hpc_pkg.sv */
// Shared constants for the host port handshake core
package hpc_pkg;
    // ------------------------------------------------------------
    // Core-side APB register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_CTRL_OFS = 8'h00;
    localparam logic [7:0] CORE_STAT_OFS = 8'h04;
    localparam logic [7:0] CORE_RX_OFS = 8'h08;
    localparam logic [7:0] CORE_TX_OFS = 8'h0C;
    localparam logic [7:0] DMA_SEL_OFS = 8'h10;
    // ------------------------------------------------------------
    // Host-side byte addresses
    // ------------------------------------------------------------
    localparam logic [2:0] HOST_CTRL_ADR = 3'h0;
    localparam logic [2:0] HOST_CVR_ADR = 3'h1;
    localparam logic [2:0] HOST_STAT_ADR = 3'h2;
    localparam logic [2:0] HOST_HIGH_ADR = 3'h5;
    localparam logic [2:0] HOST_MID_ADR = 3'h6;
    localparam logic [2:0] HOST_LOW_ADR = 3'h7;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RX_IE_BIT = 0;
    localparam int TX_IE_BIT = 1;
    localparam int CMD_IE_BIT = 2;
    localparam int FLAG_LO_BIT = 3;
    localparam int FLAG_HI_BIT = 4;
    localparam int RX_FULL_BIT = 0;
    localparam int TX_EMPTY_BIT = 1;
    localparam int CMD_PEND_BIT = 2;
    localparam int CMD_REQ_BIT = 7;
    // ------------------------------------------------------------
    // Widths, DMA source codes and reset values
    // ------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int CTRL_W = 5;
    localparam int SYNC_W = 14;
    localparam logic [4:0] DMA_SRC_RX_FULL = 5'h13;
    localparam logic [4:0] DMA_SRC_TX_EMPTY = 5'h14;
    localparam logic [4:0] CTRL_RESET = 5'h00;
endpackage : hpc_pkg

/* File: hpc_sync.sv */
// Two-flop synchroniser bank for the asynchronous host pins
`timescale 1ns/1ps
module hpc_sync #(
    parameter int WIDTH = 14
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // ------------------------------------------------------------
    // One two-stage chain per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1; // First stage, read only by stage two
            logic stage2; // Second stage, safe to use
            always_ff @(posedge clk) begin
                if (reset) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= asyncIn[i];
                    stage2 <= stage1;
                end
            end
            assign syncOut[i] = stage2;
        end
    endgenerate
endmodule : hpc_sync

/* File: hpc_core.sv */
// Host port handshake core: host byte port, core APB side, moves
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// RULE1: Host always masters; port only answers.
// RULE2: Host writes fill tx bytes, reads rx.
// RULE3: Host tx word moves when core rx empty.
// RULE4: Core tx word moves when host rx empty.
// RULE5: Host checks tx empty before writing.
// RULE6: Core status: bit1 tx empty, bit0 rx full.
// RULE7: Host status: bit1 tx empty, bit0 rx full.
// RULE8: Core flags 4:3 mirror into host status.
// RULE9: Host flags 4:3 mirror into core status.
// RULE10: Set status plus enable raises core interrupt.
// RULE11: Enables: bit0 rx, bit1 tx, bit2 command.
// RULE12: Conditions persist until core data access.
// RULE13: Host sets command bit and seven-bit vector.
// RULE14: Command interrupt address is twice the vector.
// RULE15: Only interrupt acknowledge clears pending command.
// RULE16: DMA sources: rx full 10011, tx empty 10100.
// RULE17: DMA uses core registers, never host bus.
// RULE18: Stop mode disconnects and disables the port.
// RULE19: Reset clears all core-side control registers.
// RULE20: Status bits update the cycle after change.
module hpc_core (
    input wire logic clk,
    input wire logic reset,
    // APB slave, core side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host byte bus pins
    input wire logic hostCs_n,
    input wire logic hostRd_n,
    input wire logic hostWr_n,
    input wire logic [2:0] hostAddr,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe,
    // Core interrupts, DMA and power state
    input wire logic stopMode,
    input wire logic irqAck,
    output logic irqRx,
    output logic irqTx,
    output logic irqCmd,
    output logic [7:0] irqAddr,
    output logic dmaReq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [23:0] coreRxWord, next_coreRxWord; // Core receive register
    logic [23:0] hostTxWord, next_hostTxWord; // Host transmit bytes
    logic [23:0] hostRxWord, next_hostRxWord; // Host receive bytes
    logic [23:0] coreTxWord, next_coreTxWord; // Core transmit register
    logic coreRxFull, next_coreRxFull;
    logic coreTxEmpty, next_coreTxEmpty;
    logic hostTxEmpty, next_hostTxEmpty;
    logic hostRxFull, next_hostRxFull;
    logic [4:0] coreCtrl, next_coreCtrl; // Core control register
    logic [4:0] hostCtrl, next_hostCtrl; // Host control register
    logic [4:0] dmaSel, next_dmaSel; // DMA source select code
    logic cmdPend, next_cmdPend; // Pending host command
    logic [6:0] cmdVec, next_cmdVec; // Host command vector
    logic prevWr, next_prevWr; // Host write strobe last cycle
    logic prevRd, next_prevRd; // Host read strobe last cycle
    logic [2:0] lastAddr, next_lastAddr; // Address held during strobe
    logic [7:0] lastData, next_lastData; // Data held during strobe
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [7:0] next_hostDataOut;
    logic next_hostDataOe, next_irqRx, next_irqTx, next_irqCmd;
    logic [7:0] next_irqAddr;
    logic next_dmaReq;

    // ------------------------------------------------------------
    // Host pin synchronisation
    // ------------------------------------------------------------
    logic [13:0] syncPins; // Synchronised host pins
    logic hostWrAct, hostRdAct; // Active strobes with chip select
    logic [2:0] sAddr;
    logic [7:0] sData;

    hpc_sync #(.WIDTH(hpc_pkg::SYNC_W)) u_sync (
        .clk(clk),
        .reset(reset),
        .asyncIn({~hostCs_n, ~hostRd_n, ~hostWr_n, hostAddr, hostDataIn}),
        .syncOut(syncPins)
    );

    // Strobes are ignored while the core is stopped
    assign hostRdAct = syncPins[13] & syncPins[12] & ~stopMode; // RULE18
    assign hostWrAct = syncPins[13] & syncPins[11] & ~stopMode; // RULE18
    assign sAddr = syncPins[10:8];
    assign sData = syncPins[7:0];

    // ------------------------------------------------------------
    // Derived status bytes and APB phases
    // ------------------------------------------------------------
    logic [7:0] hostStat; // Host-side status byte
    logic [7:0] coreStat; // Core-side status value
    logic apbDone; // APB access completes this edge
    logic hostWrEnd, hostRdEnd; // Host strobe trailing edges

    assign hostStat = {3'h0, coreCtrl[4:3], 1'b0, hostTxEmpty,
        hostRxFull}; // RULE7 RULE8
    assign coreStat = {3'h0, hostCtrl[4:3], cmdPend, coreTxEmpty,
        coreRxFull}; // RULE6 RULE9
    assign apbDone = psel & penable & pready;
    assign hostWrEnd = prevWr & ~hostWrAct; // RULE1
    assign hostRdEnd = prevRd & ~hostRdAct; // RULE1

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_coreRxWord = coreRxWord;
        next_hostTxWord = hostTxWord;
        next_hostRxWord = hostRxWord;
        next_coreTxWord = coreTxWord;
        next_coreRxFull = coreRxFull;
        next_coreTxEmpty = coreTxEmpty;
        next_hostTxEmpty = hostTxEmpty;
        next_hostRxFull = hostRxFull;
        next_coreCtrl = coreCtrl;
        next_hostCtrl = hostCtrl;
        next_dmaSel = dmaSel;
        next_cmdPend = cmdPend;
        next_cmdVec = cmdVec;
        next_prevWr = hostWrAct;
        next_prevRd = hostRdAct;
        next_lastAddr = sAddr;
        next_lastData = sData;
        next_prdata = 32'h0000_0000;
        next_pready = psel & penable & ~pready;
        next_pslverr = 1'b0;
        // Interrupt acknowledge clears a pending command
        if (irqAck) begin
            next_cmdPend = 1'b0; // RULE15
        end
        // Automatic move host tx bytes to core rx
        if (!hostTxEmpty && !coreRxFull) begin
            next_coreRxWord = hostTxWord; // RULE3
            next_coreRxFull = 1'b1; // RULE20
            next_hostTxEmpty = 1'b1;
        end
        // Automatic move core tx to host rx bytes
        if (!coreTxEmpty && !hostRxFull) begin
            next_hostRxWord = coreTxWord; // RULE4
            next_hostRxFull = 1'b1; // RULE20
            next_coreTxEmpty = 1'b1;
        end
        // APB read data and error prepared in the access phase
        if (psel && penable && !pready) begin
            case (paddr)
                hpc_pkg::CORE_CTRL_OFS: next_prdata = {27'h0, coreCtrl};
                hpc_pkg::CORE_STAT_OFS: next_prdata = {24'h0, coreStat};
                hpc_pkg::CORE_RX_OFS: next_prdata = {8'h00, coreRxWord};
                hpc_pkg::CORE_TX_OFS: next_prdata = 32'h0000_0000;
                hpc_pkg::DMA_SEL_OFS: next_prdata = {27'h0, dmaSel};
                default: next_pslverr = 1'b1;
            endcase
        end
        // APB side effects at the completing edge
        if (apbDone && !pslverr) begin
            if (pwrite) begin
                case (paddr)
                    hpc_pkg::CORE_CTRL_OFS: next_coreCtrl = pwdata[4:0];
                    hpc_pkg::CORE_TX_OFS: begin
                        next_coreTxWord = pwdata[23:0];
                        next_coreTxEmpty = 1'b0; // RULE12
                    end
                    hpc_pkg::DMA_SEL_OFS: next_dmaSel = pwdata[4:0];
                    default: ;
                endcase
            end else if (paddr == hpc_pkg::CORE_RX_OFS) begin
                // Only a held word is emptied; a refill needs it empty
                if (coreRxFull) begin
                    next_coreRxFull = 1'b0; // RULE12
                end
            end
        end
        // Host write completes on strobe trailing edge
        if (hostWrEnd) begin
            case (lastAddr)
                hpc_pkg::HOST_CTRL_ADR: next_hostCtrl = lastData[4:0];
                hpc_pkg::HOST_CVR_ADR: begin
                    next_cmdVec = lastData[6:0]; // RULE13
                    if (lastData[hpc_pkg::CMD_REQ_BIT]) begin
                        next_cmdPend = 1'b1; // Set wins over ack
                    end
                end
                hpc_pkg::HOST_HIGH_ADR: next_hostTxWord[23:16] = lastData;
                hpc_pkg::HOST_MID_ADR: next_hostTxWord[15:8] = lastData;
                hpc_pkg::HOST_LOW_ADR: begin
                    next_hostTxWord[7:0] = lastData; // RULE2
                    next_hostTxEmpty = 1'b0; // RULE20
                end
                default: ;
            endcase
        end
        // Host read of the low byte empties host rx
        if (hostRdEnd && lastAddr == hpc_pkg::HOST_LOW_ADR) begin
            if (hostRxFull) begin
                next_hostRxFull = 1'b0; // RULE20
            end
        end
    end

    // ------------------------------------------------------------
    // Output next values
    // ------------------------------------------------------------
    always_comb begin
        next_hostDataOe = hostRdAct; // RULE18
        case (sAddr)
            hpc_pkg::HOST_CTRL_ADR: next_hostDataOut = {3'h0, hostCtrl};
            hpc_pkg::HOST_CVR_ADR: next_hostDataOut = {cmdPend, cmdVec};
            hpc_pkg::HOST_STAT_ADR: next_hostDataOut = hostStat;
            hpc_pkg::HOST_HIGH_ADR: next_hostDataOut = hostRxWord[23:16];
            hpc_pkg::HOST_MID_ADR: next_hostDataOut = hostRxWord[15:8];
            hpc_pkg::HOST_LOW_ADR: next_hostDataOut = hostRxWord[7:0];
            default: next_hostDataOut = 8'h00;
        endcase
        next_irqRx = coreRxFull & coreCtrl[hpc_pkg::RX_IE_BIT]; // RULE10 RULE11
        next_irqTx = coreTxEmpty & coreCtrl[hpc_pkg::TX_IE_BIT]; // RULE11
        next_irqCmd = cmdPend & coreCtrl[hpc_pkg::CMD_IE_BIT]; // RULE11
        next_irqAddr = {cmdVec, 1'b0}; // RULE14
        case (dmaSel)
            hpc_pkg::DMA_SRC_RX_FULL: next_dmaReq = coreRxFull; // RULE16
            hpc_pkg::DMA_SRC_TX_EMPTY: next_dmaReq = coreTxEmpty; // RULE16
            default: next_dmaReq = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            coreRxWord <= 24'h00_0000;
            hostTxWord <= 24'h00_0000;
            hostRxWord <= 24'h00_0000;
            coreTxWord <= 24'h00_0000;
            coreRxFull <= 1'b0;
            coreTxEmpty <= 1'b1;
            hostTxEmpty <= 1'b1;
            hostRxFull <= 1'b0;
            coreCtrl <= hpc_pkg::CTRL_RESET; // RULE19
            hostCtrl <= hpc_pkg::CTRL_RESET;
            dmaSel <= hpc_pkg::CTRL_RESET; // RULE19
            cmdPend <= 1'b0;
            cmdVec <= 7'h00;
            prevWr <= 1'b0;
            prevRd <= 1'b0;
            lastAddr <= 3'h0;
            lastData <= 8'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            hostDataOut <= 8'h00;
            hostDataOe <= 1'b0;
            irqRx <= 1'b0;
            irqTx <= 1'b0;
            irqCmd <= 1'b0;
            irqAddr <= 8'h00;
            dmaReq <= 1'b0;
        end else begin
            coreRxWord <= next_coreRxWord;
            hostTxWord <= next_hostTxWord;
            hostRxWord <= next_hostRxWord;
            coreTxWord <= next_coreTxWord;
            coreRxFull <= next_coreRxFull;
            coreTxEmpty <= next_coreTxEmpty;
            hostTxEmpty <= next_hostTxEmpty;
            hostRxFull <= next_hostRxFull;
            coreCtrl <= next_coreCtrl;
            hostCtrl <= next_hostCtrl;
            dmaSel <= next_dmaSel;
            cmdPend <= next_cmdPend;
            cmdVec <= next_cmdVec;
            prevWr <= next_prevWr;
            prevRd <= next_prevRd;
            lastAddr <= next_lastAddr;
            lastData <= next_lastData;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            hostDataOut <= next_hostDataOut;
            hostDataOe <= next_hostDataOe;
            irqRx <= next_irqRx;
            irqTx <= next_irqTx;
            irqCmd <= next_irqCmd;
            irqAddr <= next_irqAddr;
            dmaReq <= next_dmaReq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_host_to_core: assert property ( // RULE3
        !hostTxEmpty && !coreRxFull |=> coreRxFull && $past(hostTxWord) == coreRxWord)
        else $error("host word not moved to core");
    a_core_to_host: assert property ( // RULE4
        !coreTxEmpty && !hostRxFull |=> hostRxFull && hostRxWord == $past(coreTxWord))
        else $error("core word not moved to host");
    a_no_overrun: assert property ( // RULE3
        coreRxFull && !(apbDone && !pwrite && paddr == hpc_pkg::CORE_RX_OFS)
        |=> coreRxFull && $stable(coreRxWord))
        else $error("core rx overwritten");
    a_irq_rx_en: assert property ( // RULE10
        coreRxFull && coreCtrl[0] |=> irqRx)
        else $error("rx interrupt missing");
    a_irq_tx_mask: assert property ( // RULE11
        !coreCtrl[1] |=> !irqTx)
        else $error("tx interrupt not masked");
    a_cmd_clear: assert property ( // RULE15
        cmdPend && !irqAck && !hostWrEnd |=> cmdPend)
        else $error("command cleared without ack");
    a_cmd_addr: assert property ( // RULE14
        irqCmd |-> irqAddr == {$past(cmdVec), 1'b0})
        else $error("command address wrong");
    a_dma_src: assert property ( // RULE16
        dmaSel == hpc_pkg::DMA_SRC_TX_EMPTY && coreTxEmpty |=> dmaReq)
        else $error("dma tx request missing");
    a_stop_quiet: assert property ( // RULE18
        stopMode [*2] |-> !hostDataOe)
        else $error("port drives pins in stop");
    a_flag_mirror: assert property ( // RULE9
        hostWrEnd && lastAddr == hpc_pkg::HOST_CTRL_ADR
        |=> coreStat[4:3] == $past(lastData[4:3]))
        else $error("flags not mirrored");

    c_host_word: cover property (hostWrEnd && lastAddr == hpc_pkg::HOST_LOW_ADR);
    c_core_read: cover property (apbDone && !pwrite && coreRxFull);
    c_cmd_ack: cover property (cmdPend ##1 !cmdPend);
endmodule : hpc_core

/* File: hpc_host_model.sv */
// External host processor model driving the asynchronous byte bus
`timescale 1ns/1ps
module hpc_host_model (
    input wire logic clk,
    input wire logic [7:0] hostWire,
    output logic hostCs_n,
    output logic hostRd_n,
    output logic hostWr_n,
    output logic [2:0] hostAddr,
    output logic [7:0] hostDrv
);
    // ------------------------------------------------------------
    // Idle bus: strobes high, data not driven
    // ------------------------------------------------------------
    initial begin
        hostCs_n = 1'b1;
        hostRd_n = 1'b1;
        hostWr_n = 1'b1;
        hostAddr = 3'h0;
        hostDrv = 8'h00;
    end
    // One strobe cycle; the host always starts it (port only answers)
    task automatic cycle(input logic wr, input logic [2:0] a,
                         input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        hostAddr <= a;
        hostDrv <= d;
        hostCs_n <= 1'b0;
        if (wr) begin
            hostWr_n <= 1'b0;
        end else begin
            hostRd_n <= 1'b0;
        end
        // Held long enough for the two-flop sampling
        repeat (4) @(posedge clk);
        q = hostWire;
        hostCs_n <= 1'b1;
        hostWr_n <= 1'b1;
        hostRd_n <= 1'b1;
        // Keep data a while, then let the released bus wander
        repeat (3) @(posedge clk);
        hostDrv <= ~d;
        repeat (3) @(posedge clk);
    endtask : cycle
    // Single byte write
    task automatic wrByte(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        cycle(1'b1, a, d, q);
    endtask : wrByte
    // Single byte read; own data lines are released meanwhile
    task automatic rdByte(input logic [2:0] a, output logic [7:0] q);
        cycle(1'b0, a, ~hostDrv, q);
    endtask : rdByte
    // Word write, high byte first, after seeing tx empty
    task automatic wrWord(input logic [23:0] w);
        logic [7:0] s;
        s = 8'h00;
        // Poll until tx empty; the bench timeout ends a hang
        do begin
            rdByte(hpc_pkg::HOST_STAT_ADR, s);
        end while (s[1] !== 1'b1);
        wrByte(hpc_pkg::HOST_HIGH_ADR, w[23:16]);
        wrByte(hpc_pkg::HOST_MID_ADR, w[15:8]);
        wrByte(hpc_pkg::HOST_LOW_ADR, w[7:0]);
    endtask : wrWord
    // Word read after seeing rx full; low byte read empties the buffer
    task automatic rdWord(output logic [23:0] w);
        logic [7:0] s;
        s = 8'h00;
        // Own handshake decides when data is there
        do begin
            rdByte(hpc_pkg::HOST_STAT_ADR, s);
        end while (s[0] !== 1'b1);
        rdByte(hpc_pkg::HOST_HIGH_ADR, w[23:16]);
        rdByte(hpc_pkg::HOST_MID_ADR, w[15:8]);
        rdByte(hpc_pkg::HOST_LOW_ADR, w[7:0]);
    endtask : rdWord
endmodule : hpc_host_model

/* File: hpc_core_tb.sv */
// Self-checking bench for the host port handshake core
`timescale 1ns/1ps
module hpc_core_tb;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hostCs_n;
    logic hostRd_n;
    logic hostWr_n;
    logic [2:0] hostAddr;
    logic [7:0] hostDrv;
    logic [7:0] hostDataOut;
    logic hostDataOe;
    logic [7:0] hostWire;
    logic stopMode = 1'b0;
    logic irqAck = 1'b0;
    logic irqRx;
    logic irqTx;
    logic irqCmd;
    logic dmaReq;
    logic [7:0] irqAddr;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [23:0] h2c[$];
    logic [23:0] c2h[$];
    logic [31:0] q;
    logic e;
    logic [7:0] b;
    logic [23:0] w;
    logic [6:0] vec;
    // Data wire level: port drives when enabled, else the host side
    assign hostWire = (hostDataOe === 1'b1) ? hostDataOut : hostDrv;
    always #2.5 clk = ~clk;
    // ------------------------------------------------------------
    // Device and host
    // ------------------------------------------------------------
    hpc_core dut (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hostCs_n(hostCs_n), .hostRd_n(hostRd_n),
        .hostWr_n(hostWr_n), .hostAddr(hostAddr), .hostDataIn(hostWire),
        .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .stopMode(stopMode), .irqAck(irqAck), .irqRx(irqRx),
        .irqTx(irqTx), .irqCmd(irqCmd), .irqAddr(irqAddr),
        .dmaReq(dmaReq));
    hpc_host_model host (.clk(clk), .hostWire(hostWire),
        .hostCs_n(hostCs_n), .hostRd_n(hostRd_n), .hostWr_n(hostWr_n),
        .hostAddr(hostAddr), .hostDrv(hostDrv));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checked=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // APB transfer: setup, access, hold until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait for pready; no timeout here, the hang guard ends a stall
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
                         input logic [31:0] m);
        apb(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
    endtask : rdchk
    task automatic hchk(input logic [7:0] x);
        host.rdByte(hpc_pkg::HOST_STAT_ADR, b);
        chk({24'h0, b & 8'h1B}, {24'h0, x});
    endtask : hchk
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(15831));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rdchk(hpc_pkg::CORE_STAT_OFS, 32'h02, 32'h1F);
        rdchk(hpc_pkg::CORE_CTRL_OFS, 32'h00, 32'h1F);
        hchk(8'h02);
        apb(1'b0, 8'h14, 32'h0, q, e);
        chk(32'(e), 32'h1);
        // Interrupt enables: tx empty fires at once
        wr(hpc_pkg::CORE_CTRL_OFS, 32'h07);
        waitc(3);
        chk(32'(irqTx), 32'h1);
        chk(32'(irqRx), 32'h0);
        // Host to core: second word waits for the core read
        for (int i = 0; i < 2; i++) begin
            h2c.push_back(24'($urandom()));
            host.wrWord(h2c[i]);
        end
        waitc(4);
        hchk(8'h00);
        wr(hpc_pkg::DMA_SEL_OFS, 32'h13);
        waitc(3);
        chk(32'(dmaReq), 32'h1);
        chk(32'(irqRx), 32'h1);
        for (int i = 0; i < 2; i++) begin
            rdchk(hpc_pkg::CORE_RX_OFS, 32'(h2c.pop_front()), 32'hFFFFFF);
            waitc(4);
        end
        rdchk(hpc_pkg::CORE_STAT_OFS, 32'h02, 32'h03);
        chk(32'(irqRx), 32'h0);
        chk(32'(dmaReq), 32'h0);
        wr(hpc_pkg::DMA_SEL_OFS, 32'h14);
        waitc(3);
        chk(32'(dmaReq), 32'h1);
        // Core to host, back to back
        for (int i = 0; i < 2; i++) begin
            c2h.push_back(24'($urandom()));
            wr(hpc_pkg::CORE_TX_OFS, 32'(c2h[i]));
        end
        waitc(4);
        rdchk(hpc_pkg::CORE_STAT_OFS, 32'h00, 32'h02);
        chk(32'(irqTx), 32'h0);
        chk(32'(dmaReq), 32'h0);
        for (int i = 0; i < 2; i++) begin
            host.rdWord(w);
            chk(32'(w), 32'(c2h.pop_front()));
        end
        waitc(4);
        rdchk(hpc_pkg::CORE_STAT_OFS, 32'h02, 32'h03);
        hchk(8'h02);
        // General flags both ways, every value
        for (int f = 0; f < 4; f++) begin
            wr(hpc_pkg::CORE_CTRL_OFS, 32'((f << 3) | 7));
            host.wrByte(hpc_pkg::HOST_CTRL_ADR, 8'((3 - f) << 3));
            waitc(4);
            hchk(8'((f << 3) | 2));
            rdchk(hpc_pkg::CORE_STAT_OFS, 32'(((3 - f) << 3) | 2), 32'h1B);
        end
        // Host command: data access leaves it, acknowledge clears it
        vec = 7'($urandom());
        host.wrByte(hpc_pkg::HOST_CVR_ADR, {1'b1, vec});
        waitc(4);
        chk(32'(irqCmd), 32'h1);
        chk(32'(irqAddr), 32'({vec, 1'b0}));
        apb(1'b0, hpc_pkg::CORE_RX_OFS, 32'h0, q, e);
        waitc(2);
        chk(32'(irqCmd), 32'h1);
        @(posedge clk);
        irqAck <= 1'b1;
        @(posedge clk);
        irqAck <= 1'b0;
        waitc(3);
        chk(32'(irqCmd), 32'h0);
        // Masked: tx empty stays but no request
        wr(hpc_pkg::CORE_CTRL_OFS, 32'h00);
        waitc(3);
        chk(32'(irqTx), 32'h0);
        // Stop state: host write must be ignored
        @(posedge clk);
        stopMode <= 1'b1;
        host.wrByte(hpc_pkg::HOST_LOW_ADR, 8'h5A);
        waitc(4);
        stopMode <= 1'b0;
        waitc(4);
        rdchk(hpc_pkg::CORE_STAT_OFS, 32'h02, 32'h03);
        hchk(8'h02);
        final_report();
    end
endmodule : hpc_core_tb
